// File: rtl/svmm_top.sv
// Supply voltage min/max capture with coherent two-byte register reads
`timescale 1ns/1ps
`default_nettype none
`include "svmm_consts.svh"
module svmm_top #(
    parameter int CODE_W = `SVMM_CODE_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Converter samples
    input wire logic sample_valid,
    input wire svmm_pkg::svmm_code_t aux_supply_pin,
    input wire svmm_pkg::svmm_code_t battery_supply_pin,
    input wire logic supply_present_select,
    input wire logic clear,
    // Host register port
    input wire logic reg_sel,
    input wire logic [`SVMM_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    output svmm_pkg::svmm_byte_t reg_rdata,
    output logic reg_rvalid,
    // Sample source and count weight of the last valid sample, even one dropped while frozen
    output logic meas_aux,
    output svmm_pkg::svmm_byte_t lsb_weight
);
    import svmm_pkg::*;

    svmm_code_t min_val;
    svmm_code_t max_val;
    svmm_code_t sample;
    svmm_byte_t shadow_min;
    svmm_byte_t shadow_max;
    svmm_byte_t next_shadow_min;
    svmm_byte_t next_shadow_max;
    svmm_byte_t next_rdata;
    svmm_byte_t next_weight;
    logic next_rvalid;
    logic next_meas_aux;
    logic hold;

    generate
        if (CODE_W != `SVMM_CODE_W) begin : g_bad_width
            $error("svmm_top: CODE_W must be 12 to fit a nibble and a byte");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic is_capture_reg(input logic [`SVMM_ADDR_W-1:0] a);
        is_capture_reg = (a == `SVMM_ADDR_MIN_HI) || (a == `SVMM_ADDR_MIN_LO) ||
                         (a == `SVMM_ADDR_MAX_HI) || (a == `SVMM_ADDR_MAX_LO);
    endfunction : is_capture_reg

    function automatic svmm_byte_t upper_part(input svmm_code_t c);
        upper_part = {`SVMM_RSVD_NIBBLE, c[CODE_W-1:`SVMM_LO_W]};
    endfunction : upper_part

    ////////////////////////////////////////////////////////////////////////////////
    // Source select and freeze

    // Samples that arrive while frozen are dropped, not queued: a host that
    // parks its address on these offsets loses extremes for that time.
    assign hold = reg_sel && is_capture_reg(reg_addr);
    assign sample = (supply_present_select == `SVMM_SEL_AUX) ? aux_supply_pin
                                                             : battery_supply_pin;

    svmm_tracker #(
        .CODE_W(CODE_W),
        .IS_MAX(1'b0)
    ) u_min (
        .clk(clk),
        .rstn(rstn),
        .clear(clear),
        .hold(hold),
        .sample_valid(sample_valid),
        .sample(sample),
        .value(min_val)
    );

    svmm_tracker #(
        .CODE_W(CODE_W),
        .IS_MAX(1'b1)
    ) u_max (
        .clk(clk),
        .rstn(rstn),
        .clear(clear),
        .hold(hold),
        .sample_valid(sample_valid),
        .sample(sample),
        .value(max_val)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads, shadows and weight

    always_comb begin
        next_shadow_min = shadow_min;
        next_shadow_max = shadow_max;
        next_rdata = reg_rdata;
        next_rvalid = 1'b0;
        next_meas_aux = meas_aux;
        next_weight = lsb_weight;
        if (sample_valid) begin
            next_meas_aux = (supply_present_select == `SVMM_SEL_AUX);
            next_weight = next_meas_aux ? `SVMM_WEIGHT_AUX : `SVMM_WEIGHT_BATT;
        end
        if (reg_sel && reg_rd) begin
            next_rvalid = 1'b1;
            unique case (reg_addr)
                `SVMM_ADDR_MIN_HI: begin
                    next_rdata = upper_part(min_val);
                    next_shadow_min = min_val[`SVMM_LO_W-1:0];
                end
                `SVMM_ADDR_MAX_HI: begin
                    next_rdata = upper_part(max_val);
                    next_shadow_max = max_val[`SVMM_LO_W-1:0];
                end
                `SVMM_ADDR_MIN_LO: begin
                    next_rdata = shadow_min;
                end
                `SVMM_ADDR_MAX_LO: begin
                    next_rdata = shadow_max;
                end
                default: begin
                    // Unmapped offsets read as zero
                    next_rdata = `SVMM_RESET_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shadow_min <= `SVMM_RESET_BYTE;
            shadow_max <= `SVMM_RESET_BYTE;
            reg_rdata <= `SVMM_RESET_BYTE;
            reg_rvalid <= 1'b0;
            meas_aux <= 1'b0;
            lsb_weight <= `SVMM_WEIGHT_BATT;
        end else begin
            shadow_min <= next_shadow_min;
            shadow_max <= next_shadow_max;
            reg_rdata <= next_rdata;
            reg_rvalid <= next_rvalid;
            meas_aux <= next_meas_aux;
            lsb_weight <= next_weight;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_min_falls_only;
        @(posedge clk) disable iff (!rstn)
        !clear |=> (min_val <= $past(min_val));
    endproperty
    a_min_falls_only: assert property (p_min_falls_only)
        else $error("minimum rose without a clear");

    property p_max_rises_only;
        @(posedge clk) disable iff (!rstn)
        !clear |=> (max_val >= $past(max_val));
    endproperty
    a_max_rises_only: assert property (p_max_rises_only)
        else $error("maximum fell without a clear");

    property p_aux_source;
        @(posedge clk) disable iff (!rstn)
        (sample_valid && !hold && !clear && supply_present_select && aux_supply_pin < min_val)
        |=> (min_val == $past(aux_supply_pin));
    endproperty
    a_aux_source: assert property (p_aux_source)
        else $error("auxiliary sample not taken as new minimum");

    property p_batt_source;
        @(posedge clk) disable iff (!rstn)
        (sample_valid && !hold && !clear && !supply_present_select &&
         battery_supply_pin > max_val) |=> (max_val == $past(battery_supply_pin));
    endproperty
    a_batt_source: assert property (p_batt_source)
        else $error("battery sample not taken as new maximum");

    property p_hold_freezes;
        @(posedge clk) disable iff (!rstn)
        (hold && !clear) |=> ($stable(min_val) && $stable(max_val));
    endproperty
    a_hold_freezes: assert property (p_hold_freezes)
        else $error("extreme changed while addressed");

    property p_shadow_copy;
        @(posedge clk) disable iff (!rstn)
        (reg_sel && reg_rd && reg_addr == `SVMM_ADDR_MAX_HI)
        |=> (shadow_max == $past(max_val[`SVMM_LO_W-1:0]));
    endproperty
    a_shadow_copy: assert property (p_shadow_copy)
        else $error("shadow not loaded on upper read");

    property p_low_from_shadow;
        @(posedge clk) disable iff (!rstn)
        (reg_sel && reg_rd && reg_addr == `SVMM_ADDR_MIN_HI) ##1
        (reg_sel && reg_rd && reg_addr == `SVMM_ADDR_MIN_LO)
        |=> (reg_rvalid && reg_rdata == $past(min_val[`SVMM_LO_W-1:0], 2));
    endproperty
    a_low_from_shadow: assert property (p_low_from_shadow)
        else $error("lower byte not from shadow");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rstn)
        (reg_sel && reg_rd && (reg_addr == `SVMM_ADDR_MIN_HI || reg_addr == `SVMM_ADDR_MAX_HI))
        |=> (reg_rdata[`SVMM_LO_W-1:CODE_W-`SVMM_LO_W] == `SVMM_RSVD_NIBBLE);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_upper_layout;
        @(posedge clk) disable iff (!rstn)
        (reg_sel && reg_rd && reg_addr == `SVMM_ADDR_MAX_HI)
        |=> (reg_rdata[CODE_W-`SVMM_LO_W-1:0] == $past(max_val[CODE_W-1:`SVMM_LO_W]));
    endproperty
    a_upper_layout: assert property (p_upper_layout)
        else $error("upper nibble misplaced");

    property p_weight;
        @(posedge clk) disable iff (!rstn)
        sample_valid |=> (lsb_weight == ($past(supply_present_select) ?
                          `SVMM_WEIGHT_AUX : `SVMM_WEIGHT_BATT));
    endproperty
    a_weight: assert property (p_weight)
        else $error("count weight does not match source");

    property p_clear_load;
        @(posedge clk) disable iff (!rstn)
        clear |=> (min_val == `SVMM_MIN_CLEAR && max_val == `SVMM_MAX_CLEAR);
    endproperty
    a_clear_load: assert property (p_clear_load)
        else $error("clear did not load start values");
endmodule : svmm_top
`default_nettype wire

// File: pkg/svmm_consts.svh
// Constants of the supply voltage min/max capture block
// What this block does
// - Minimum register pair holds lowest supply sample since last clear, 12 bits.
// - Maximum register pair holds highest supply sample since last clear, 12 bits.
// - Track auxiliary pin when supply-present select is one, else battery pin.
// - While any of these registers is addressed, stored extremes take no samples; a clear still loads their start values.
// - Reading an upper nibble register copies its lower byte into a shadow.
// - Reading a lower byte register returns the shadow, not the live byte.
// - Upper register bits 7:4 read zero; host writes only zero there.
// - Upper four code bits in upper register 3:0, lower eight in lower register.
// - All four min and max registers reset to zero.
// - One count weighs 1.49 mV on battery pin, 1.01 mV on auxiliary pin.
`ifndef SVMM_CONSTS_SVH
`define SVMM_CONSTS_SVH

`define SVMM_CODE_W 12
`define SVMM_LO_W 8
`define SVMM_ADDR_W 8

// Register offsets on the host register port
`define SVMM_ADDR_MIN_HI 8'h1d
`define SVMM_ADDR_MIN_LO 8'h1e
`define SVMM_ADDR_MAX_HI 8'h1f
`define SVMM_ADDR_MAX_LO 8'h20

`define SVMM_RESET_BYTE 8'h00
`define SVMM_RESET_CODE 12'h000
`define SVMM_RSVD_NIBBLE 4'h0
`define SVMM_MIN_CLEAR 12'hfff
`define SVMM_MAX_CLEAR 12'h000
`define SVMM_SEL_AUX 1'b1

// Count weight in hundredths of a millivolt: 149 and 101
`define SVMM_WEIGHT_BATT 8'h95
`define SVMM_WEIGHT_AUX 8'h65

`endif

// File: pkg/svmm_pkg.sv
// Types shared by the supply voltage min/max capture block
`default_nettype none
package svmm_pkg;
    typedef logic [11:0] svmm_code_t;
    typedef logic [7:0] svmm_byte_t;
endpackage : svmm_pkg
`default_nettype wire

// File: rtl/svmm_tracker.sv
// One extreme tracker: keeps the lowest or highest accepted sample
`timescale 1ns/1ps
`default_nettype none
`include "svmm_consts.svh"
module svmm_tracker #(
    parameter int CODE_W = `SVMM_CODE_W,
    parameter bit IS_MAX = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic clear,
    input wire logic hold,
    input wire logic sample_valid,
    input wire logic [CODE_W-1:0] sample,
    // Result
    output logic [CODE_W-1:0] value
);
    logic [CODE_W-1:0] next_value;
    logic better;

    generate
        if (CODE_W != `SVMM_CODE_W) begin : g_bad_width
            $error("svmm_tracker: CODE_W must be 12");
        end
    endgenerate

    always_comb begin
        better = IS_MAX ? (sample > value) : (sample < value);
        next_value = value;
        if (clear) begin
            // Start point that any first sample displaces
            next_value = IS_MAX ? CODE_W'(`SVMM_MAX_CLEAR) : CODE_W'(`SVMM_MIN_CLEAR);
        end else if (sample_valid && !hold && better) begin
            next_value = sample;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            value <= CODE_W'(`SVMM_RESET_CODE);
        end else begin
            value <= next_value;
        end
    end
endmodule : svmm_tracker
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the supply voltage min/max capture block
`timescale 1ns/1ps
`default_nettype none
`include "svmm_consts.svh"
module testbench;
    import svmm_pkg::*;
    logic clk;
    logic rstn;
    logic sample_valid;
    svmm_code_t aux_supply_pin;
    svmm_code_t battery_supply_pin;
    logic supply_present_select;
    logic clear;
    logic reg_sel;
    logic [`SVMM_ADDR_W-1:0] reg_addr;
    logic reg_rd;
    svmm_byte_t reg_rdata;
    logic reg_rvalid;
    logic meas_aux;
    svmm_byte_t lsb_weight;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    svmm_top dut (.clk(clk), .rstn(rstn), .sample_valid(sample_valid),
        .aux_supply_pin(aux_supply_pin), .battery_supply_pin(battery_supply_pin),
        .supply_present_select(supply_present_select), .clear(clear),
        .reg_sel(reg_sel), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .meas_aux(meas_aux), .lsb_weight(lsb_weight));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // The tests take about a hundred cycles; a hang is cut well beyond that
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Upper then lower, back to back, as a host reads a coherent pair
    task automatic rdpair(input logic [7:0] a, input svmm_code_t code);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_addr <= a + 8'h01;
        #1;
        chk("upper valid", 8'h01, {7'h00, reg_rvalid});
        chk("upper byte", {4'h0, code[11:8]}, reg_rdata);
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_sel <= 1'b0;
        #1;
        chk("lower byte", code[7:0], reg_rdata);
    endtask : rdpair

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_sel <= 1'b0;
        #1;
        chk("single valid", 8'h01, {7'h00, reg_rvalid});
        chk("single byte", exp, reg_rdata);
    endtask : rd

    task automatic smp(input svmm_code_t a, input svmm_code_t b, input logic s);
        @(posedge clk);
        sample_valid <= 1'b1;
        aux_supply_pin <= a;
        battery_supply_pin <= b;
        supply_present_select <= s;
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
        chk("source", {7'h00, s}, {7'h00, meas_aux});
        chk("weight", s ? 8'h65 : 8'h95, lsb_weight);
    endtask : smp

    task automatic clr();
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
    endtask : clr

    initial begin
        {rstn, sample_valid, supply_present_select, clear, reg_sel, reg_rd} = 6'h00;
        aux_supply_pin = 12'h000;
        battery_supply_pin = 12'h000;
        reg_addr = 8'h00;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdpair(8'h1d, 12'h000);
        rdpair(8'h1f, 12'h000);
        $display("test reset done");
        // Unselected pin carries the value that would win if picked by mistake
        clr();
        smp(12'h001, 12'h800, 1'b0);
        smp(12'hffe, 12'h3c1, 1'b0);
        smp(12'h001, 12'ha55, 1'b0);
        rdpair(8'h1d, 12'h3c1);
        rdpair(8'h1f, 12'ha55);
        smp(12'h2b7, 12'h000, 1'b1);
        smp(12'hc4e, 12'hfff, 1'b1);
        rdpair(8'h1d, 12'h2b7);
        rdpair(8'h1f, 12'hc4e);
        $display("test tracking done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            reg_sel <= 1'b1;
            reg_addr <= 8'h1d + 8'(i);
            smp(12'h000, 12'h000, 1'b1);
            smp(12'hfff, 12'hfff, 1'b1);
            @(posedge clk);
            reg_sel <= 1'b0;
        end
        rdpair(8'h1d, 12'h2b7);
        rdpair(8'h1f, 12'hc4e);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_addr <= 8'h30;
        smp(12'hfff, 12'h000, 1'b1);
        @(posedge clk);
        reg_sel <= 1'b0;
        rdpair(8'h1f, 12'hfff);
        rd(8'h30, 8'h00);
        // Clear takes priority over a sample in the same cycle
        @(posedge clk);
        clear <= 1'b1;
        sample_valid <= 1'b1;
        aux_supply_pin <= 12'h555;
        @(posedge clk);
        clear <= 1'b0;
        sample_valid <= 1'b0;
        rdpair(8'h1d, 12'hfff);
        rdpair(8'h1f, 12'h000);
        $display("test freeze and clear done");
        smp(12'h5a3, 12'h000, 1'b1);
        rd(8'h1f, 8'h05);
        smp(12'h6c4, 12'h000, 1'b1);
        rd(8'h20, 8'ha3);
        rd(8'h1e, 8'hff);
        rd(8'h1f, 8'h06);
        rd(8'h20, 8'hc4);
        @(posedge clk);
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("unselected read valid", 8'h00, {7'h00, reg_rvalid});
        $display("test shadow done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
